// >>> verilog/instr_decode_pkg.sv
// Constants shared by the mixed-width instruction decoder
// Operation
// RL1 - Compact and full encodings mix freely
// RL2 - Full encoding names two sources, one destination
// RL3 - Registers zero to 28 are general purpose
// RL4 - Source register 62 selects long immediate
// RL5 - Register 63 reads aligned PC, read-only
// RL6 - Compact fields reach r0-r3, r12-r15 only
// RL7 - Compact destination doubles as first source
// RL8 - Compact branch 512 bytes, full 16 megabytes
// RL9 - Compact: no delay slot, always unconditional
// RL10 - Compact flags only for test and compare
// RL11 - Auxiliary space reached by special loads/stores
// RL12 - Two modes; kernel entered on reset
// RL13 - User privileged access raises exception
// RL14 - Mode is exported to memory management
// RL15 - Five-bit group: eight full, 24 compact
// RL16 - 64 registers; 32 to 59 for extensions
// RL17 - Aligned PC clears two low bits
package instr_decode_pkg;
  localparam int          REG_W         = 6;
  localparam int          MAJOR_W       = 5;
  localparam int          MAJOR_LSB     = 27;
  localparam logic [4:0]  FULL_GROUPS   = 5'h08;
  localparam logic [5:0]  LIMM_REG      = 6'h3E;
  localparam logic [5:0]  PC_REG        = 6'h3F;
  localparam logic [5:0]  GPR_LAST      = 6'h1C;
  localparam logic [5:0]  EXT_FIRST     = 6'h20;
  localparam logic [5:0]  EXT_LAST      = 6'h3B;
  localparam int          A_LSB         = 0;
  localparam int          B_LSB         = 6;
  localparam int          C_LSB         = 12;
  localparam int          FLAG_BIT      = 18;
  localparam int          COND_LSB      = 19;
  localparam int          DSLOT_BIT     = 23;
  localparam int          MINOR_LSB     = 24;
  localparam int          CB_LSB        = 0;
  localparam int          CC_LSB        = 3;
  localparam int          CMINOR_LSB    = 6;
  // Major groups given special meaning here
  localparam logic [4:0]  GRP_BRANCH    = 5'h00;
  localparam logic [4:0]  GRP_AUX       = 5'h04;
  localparam logic [4:0]  GRP_PRIV      = 5'h05;
  localparam logic [4:0]  GRP_CBRANCH   = 5'h1E;
  localparam logic [4:0]  GRP_CTEST     = 5'h0F;
  localparam logic [2:0]  MINOR_AUX_LD  = 3'h0;
  localparam logic [2:0]  MINOR_AUX_ST  = 3'h1;
  localparam logic [2:0]  CMINOR_BTST   = 3'h0;
  localparam logic [2:0]  CMINOR_CMP    = 3'h1;
  localparam logic [2:0]  CMINOR_TST    = 3'h2;
  localparam int          FULL_DISP_W   = 24;
  localparam int          CMP_DISP_W    = 9;
  localparam logic [4:0]  COND_ALWAYS   = 5'h00;
  typedef enum logic {mode_kernel, mode_user} priv_mode_e;
endpackage

// >>> verilog/compact_reg_map.sv
// Expands a three-bit compact register field to a core register index
module compact_reg_map (
  // Compact field
  input  wire logic [2:0] short_sel,
  // Full index
  output      logic [5:0] reg_idx
);
  always_comb begin
    reg_idx = {2'b00, short_sel[2], short_sel[2], short_sel[1:0]}; // RL6
  end
endmodule // compact_reg_map

// >>> verilog/mixed_width_instr_decode.sv
// Mixed 16/32-bit instruction decode stage with privilege check
module mixed_width_instr_decode (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Fetch side
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr_word,
  input  wire logic [31:0] instr_addr,
  input  wire logic [31:0] limm_word,
  // Mode control from the commit stage
  input  wire logic        enter_user,
  input  wire logic        enter_kernel,
  // Decoded result
  output      logic        dec_valid,
  output      logic        dec_is_compact,
  output      logic [5:0]  dec_src1,
  output      logic [5:0]  dec_src2,
  output      logic [5:0]  dec_dst,
  output      logic        dec_dst_en,
  output      logic        dec_src1_limm,
  output      logic        dec_src2_limm,
  output      logic        dec_src1_pc,
  output      logic        dec_src2_pc,
  output      logic [31:0] dec_limm,
  output      logic [31:0] aligned_pc_source,
  output      logic        dec_uses_ext_reg,
  output      logic        dec_flag_en,
  output      logic [4:0]  dec_cond,
  output      logic        dec_delay_slot,
  output      logic        dec_is_branch,
  output      logic [31:0] dec_branch_target,
  output      logic        aux_load_instr,
  output      logic        aux_store_instr,
  output      logic        priv_exception,
  // Mode to memory management
  output      logic        user_mode
);
  instr_decode_pkg::priv_mode_e mode_reg, mode_next;
  logic        valid_reg, valid_next, cmp_reg, cmp_next;
  logic [5:0]  s1_reg, s1_next, s2_reg, s2_next, d_reg, d_next;
  logic        den_reg, den_next, l1_reg, l1_next, l2_reg, l2_next;
  logic        p1_reg, p1_next, p2_reg, p2_next, ext_reg, ext_next;
  logic        fl_reg, fl_next, ds_reg, ds_next, br_reg, br_next;
  logic        al_reg, al_next, as_reg, as_next, exc_reg, exc_next;
  logic [4:0]  cond_reg, cond_next;
  logic [31:0] limm_reg, limm_next, pc_reg, pc_next, tgt_reg, tgt_next;
  logic [4:0]  major;
  logic        compact;
  logic [5:0]  cb_idx, cc_idx;
  logic [2:0]  cminor;

  function automatic logic is_ext(input logic [5:0] r);
    is_ext = (r >= instr_decode_pkg::EXT_FIRST)
          && (r <= instr_decode_pkg::EXT_LAST); // RL16
  endfunction

  // Compact parcel sits in the upper halfword
  compact_reg_map u_map_b (
    .short_sel (instr_word[16+instr_decode_pkg::CB_LSB +: 3]),
    .reg_idx   (cb_idx)
  );
  compact_reg_map u_map_c (
    .short_sel (instr_word[16+instr_decode_pkg::CC_LSB +: 3]),
    .reg_idx   (cc_idx)
  );

  assign major = instr_word[instr_decode_pkg::MAJOR_LSB +:
                            instr_decode_pkg::MAJOR_W]; // RL15
  assign compact = (major >= instr_decode_pkg::FULL_GROUPS); // RL1 RL15
  assign cminor = instr_word[16+instr_decode_pkg::CMINOR_LSB +: 3];

  always_comb begin
    mode_next = mode_reg;
    valid_next = instr_valid;
    cmp_next = compact;
    s1_next = 6'h00;
    s2_next = 6'h00;
    d_next = 6'h00;
    den_next = 1'b0;
    fl_next = 1'b0;
    cond_next = instr_decode_pkg::COND_ALWAYS;
    ds_next = 1'b0;
    br_next = 1'b0;
    al_next = 1'b0;
    as_next = 1'b0;
    exc_next = 1'b0;
    tgt_next = tgt_reg;
    limm_next = limm_reg;
    pc_next = {instr_addr[31:2], 2'b00}; // RL5 RL17
    if (enter_kernel) begin
      mode_next = instr_decode_pkg::mode_kernel;
    end else if (enter_user) begin
      mode_next = instr_decode_pkg::mode_user;
    end
    if (instr_valid) begin
      if (compact) begin
        s1_next = cb_idx; // RL7
        d_next = cb_idx; // RL7
        s2_next = cc_idx;
        den_next = 1'b1;
        if (major == instr_decode_pkg::GRP_CTEST) begin
          den_next = 1'b0;
          fl_next = (cminor == instr_decode_pkg::CMINOR_BTST)
                 || (cminor == instr_decode_pkg::CMINOR_CMP)
                 || (cminor == instr_decode_pkg::CMINOR_TST); // RL10
        end
        if (major == instr_decode_pkg::GRP_CBRANCH) begin
          br_next = 1'b1;
          den_next = 1'b0;
          tgt_next = pc_next + {{22{instr_word[16+8]}},
                     instr_word[16 +: 9], 1'b0}; // RL8
        end
        // Compact keeps cond always and no delay slot
        ds_next = 1'b0; // RL9
        cond_next = instr_decode_pkg::COND_ALWAYS; // RL9
      end else begin
        s1_next = instr_word[instr_decode_pkg::B_LSB +: 6]; // RL2
        s2_next = instr_word[instr_decode_pkg::C_LSB +: 6]; // RL2
        d_next = instr_word[instr_decode_pkg::A_LSB +: 6]; // RL2 RL3
        den_next = (d_next != instr_decode_pkg::PC_REG)
                && (d_next != instr_decode_pkg::LIMM_REG); // RL5
        fl_next = instr_word[instr_decode_pkg::FLAG_BIT];
        cond_next = instr_word[instr_decode_pkg::COND_LSB +: 5];
        ds_next = instr_word[instr_decode_pkg::DSLOT_BIT];
        if (major == instr_decode_pkg::GRP_BRANCH) begin
          br_next = 1'b1;
          den_next = 1'b0;
          tgt_next = pc_next + {{7{instr_word[23]}},
                     instr_word[0 +: 24], 1'b0}; // RL8
        end
        if (major == instr_decode_pkg::GRP_AUX) begin
          // Aux space is separate from memory
          al_next = instr_word[instr_decode_pkg::MINOR_LSB +: 3]
                 == instr_decode_pkg::MINOR_AUX_LD; // RL11
          as_next = instr_word[instr_decode_pkg::MINOR_LSB +: 3]
                 == instr_decode_pkg::MINOR_AUX_ST; // RL11
          // Aux load still may not write r62 or r63
          den_next = den_next && al_next; // RL5
        end
        if (((major == instr_decode_pkg::GRP_AUX) && as_next)
            || (major == instr_decode_pkg::GRP_PRIV)) begin
          exc_next = (mode_reg == instr_decode_pkg::mode_user); // RL13
        end
      end
      if (exc_next) begin
        // Suppress write, aux access and branch of the faulting instruction
        den_next = 1'b0;
        al_next = 1'b0;
        as_next = 1'b0;
        br_next = 1'b0;
      end
      if ((s1_next == instr_decode_pkg::LIMM_REG)
          || (s2_next == instr_decode_pkg::LIMM_REG)) begin
        limm_next = limm_word; // RL4
      end
    end
    l1_next = instr_valid && (s1_next == instr_decode_pkg::LIMM_REG); // RL4
    l2_next = instr_valid && (s2_next == instr_decode_pkg::LIMM_REG); // RL4
    p1_next = instr_valid && (s1_next == instr_decode_pkg::PC_REG); // RL5
    p2_next = instr_valid && (s2_next == instr_decode_pkg::PC_REG); // RL5
    ext_next = instr_valid && (is_ext(s1_next) || is_ext(s2_next)
             || (den_next && is_ext(d_next))); // RL16
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= instr_decode_pkg::mode_kernel; // RL12
      valid_reg <= 1'b0;
      cmp_reg <= 1'b0;
      s1_reg <= 6'h00;
      s2_reg <= 6'h00;
      d_reg <= 6'h00;
      den_reg <= 1'b0;
      l1_reg <= 1'b0;
      l2_reg <= 1'b0;
      p1_reg <= 1'b0;
      p2_reg <= 1'b0;
      ext_reg <= 1'b0;
      fl_reg <= 1'b0;
      cond_reg <= 5'h00;
      ds_reg <= 1'b0;
      br_reg <= 1'b0;
      al_reg <= 1'b0;
      as_reg <= 1'b0;
      exc_reg <= 1'b0;
      limm_reg <= 32'h00000000;
      pc_reg <= 32'h00000000;
      tgt_reg <= 32'h00000000;
    end else begin
      mode_reg <= mode_next;
      valid_reg <= valid_next;
      cmp_reg <= cmp_next;
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      d_reg <= d_next;
      den_reg <= den_next;
      l1_reg <= l1_next;
      l2_reg <= l2_next;
      p1_reg <= p1_next;
      p2_reg <= p2_next;
      ext_reg <= ext_next;
      fl_reg <= fl_next;
      cond_reg <= cond_next;
      ds_reg <= ds_next;
      br_reg <= br_next;
      al_reg <= al_next;
      as_reg <= as_next;
      exc_reg <= exc_next;
      limm_reg <= limm_next;
      pc_reg <= pc_next;
      tgt_reg <= tgt_next;
    end
  end

  assign dec_valid = valid_reg;
  assign dec_is_compact = cmp_reg;
  assign dec_src1 = s1_reg;
  assign dec_src2 = s2_reg;
  assign dec_dst = d_reg;
  assign dec_dst_en = den_reg;
  assign dec_src1_limm = l1_reg;
  assign dec_src2_limm = l2_reg;
  assign dec_src1_pc = p1_reg;
  assign dec_src2_pc = p2_reg;
  assign dec_limm = limm_reg;
  assign aligned_pc_source = pc_reg;
  assign dec_uses_ext_reg = ext_reg;
  assign dec_flag_en = fl_reg;
  assign dec_cond = cond_reg;
  assign dec_delay_slot = ds_reg;
  assign dec_is_branch = br_reg;
  assign dec_branch_target = tgt_reg;
  assign aux_load_instr = al_reg;
  assign aux_store_instr = as_reg;
  assign priv_exception = exc_reg;
  assign user_mode = (mode_reg == instr_decode_pkg::mode_user); // RL14
endmodule // mixed_width_instr_decode

// >>> tb/decode_monitor.sv
// Concurrent checks on the decoder top ports
module decode_monitor (
  // Clock, reset, inputs
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic        enter_user,
  input wire logic        enter_kernel,
  // Outputs watched
  input wire logic        dec_valid,
  input wire logic        dec_is_compact,
  input wire logic [5:0]  dec_src1,
  input wire logic [5:0]  dec_dst,
  input wire logic        dec_dst_en,
  input wire logic        dec_src1_limm,
  input wire logic        dec_src1_pc,
  input wire logic [31:0] aligned_pc_source,
  input wire logic [4:0]  dec_cond,
  input wire logic        dec_delay_slot,
  input wire logic        aux_store_instr,
  input wire logic        priv_exception,
  input wire logic        user_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_user_req;
    enter_user && !enter_kernel;
  endsequence
  sequence s_priv_fetch;
    instr_valid && user_mode &&
      instr_word[31:27] == instr_decode_pkg::GRP_PRIV;
  endsequence
  a_valid_follows: assert property (instr_valid |=> dec_valid)
    else $error("decode missing after accepted word");
  a_group_width: assert property (instr_valid |=> dec_is_compact ==
    ($past(instr_word[31:27]) >= instr_decode_pkg::FULL_GROUPS))
    else $error("compact flag disagrees with group");
  a_compact_range: assert property (dec_valid && dec_is_compact |->
    dec_src1[5:4] == 2'h0 && dec_src1[3] == dec_src1[2])
    else $error("compact source outside reduced set");
  a_compact_shared: assert property (dec_valid && dec_is_compact |->
    dec_dst == dec_src1) else $error("compact dst differs from src");
  a_compact_plain: assert property (dec_valid && dec_is_compact |->
    dec_cond == 5'h00 && !dec_delay_slot)
    else $error("compact decode carries condition or slot");
  a_limm_select: assert property (dec_valid |->
    dec_src1_limm == (dec_src1 == instr_decode_pkg::LIMM_REG))
    else $error("long immediate select wrong");
  a_pc_source: assert property (dec_valid |-> aligned_pc_source[1:0] ==
    2'h0 && dec_src1_pc == (dec_src1 == instr_decode_pkg::PC_REG))
    else $error("pc source not aligned or misflagged");
  a_pc_readonly: assert property (dec_dst_en |->
    dec_dst != instr_decode_pkg::PC_REG) else $error("pc register written");
  a_user_priv: assert property (s_priv_fetch |=> priv_exception)
    else $error("privileged group passed in user mode");
  a_exc_blocks: assert property (priv_exception |->
    !dec_dst_en && !aux_store_instr) else $error("faulting op completed");
  a_kernel_clean: assert property (!user_mode |=> !priv_exception)
    else $error("exception raised in kernel mode");
  a_enter_user: assert property (s_user_req |=> user_mode)
    else $error("user mode not reported");
  a_enter_kernel: assert property (enter_kernel |=> !user_mode)
    else $error("kernel mode not entered");
endmodule // decode_monitor

bind mixed_width_instr_decode decode_monitor mon (.*);

// >>> tb/fetch_model.sv
// Fetch path model: presents words, addresses and long immediates
module fetch_model (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Requests from bench
  input wire logic        req_valid,
  input wire logic [31:0] req_word,
  // To decoder
  output     logic        instr_valid,
  output     logic [31:0] instr_word,
  output     logic [31:0] instr_addr,
  output     logic [31:0] limm_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] pc_reg;
  logic [31:0] last_reg;
  // Idle bus shows inverse of last word, never a stale copy
  assign instr_valid = req_valid;
  assign instr_word  = req_valid ? req_word : ~last_reg;
  assign instr_addr  = pc_reg;
  assign limm_word   = {pc_reg[15:0], ~pc_reg[15:0]};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg   <= 32'h0000_0102;
      last_reg <= 32'h0000_0000;
    end else if (req_valid) begin
      // Length follows group: either width any order
      pc_reg   <= pc_reg + ((req_word[31:27] >= 5'h08) ? 32'h2 : 32'h4);
      last_reg <= req_word;
    end
  end
endmodule // fetch_model

// >>> tb/tb.sv
// Self-checking bench for the mixed-width decoder
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0;
  logic enter_user = 1'b0, enter_kernel = 1'b0, mode_reg = 1'b0;
  logic [31:0] req_word = 32'h0000_0000, instr_word, instr_addr, limm_word;
  logic instr_valid, dec_valid, dec_is_compact, dec_dst_en, dec_src1_limm;
  logic dec_src2_limm, dec_src1_pc, dec_src2_pc, dec_uses_ext_reg;
  logic dec_flag_en, dec_delay_slot, dec_is_branch, aux_load_instr;
  logic aux_store_instr, priv_exception, user_mode;
  logic [5:0] dec_src1, dec_src2, dec_dst;
  logic [4:0] dec_cond;
  logic [31:0] dec_limm, aligned_pc_source, dec_branch_target;
  logic e_v = 1'b0, e_cf = 1'b0, e_user = 1'b0;
  logic [17:0] e_ops = 18'h0;
  logic [7:0] e_flg = 8'h00;
  logic [31:0] e_pc = 32'h0, e_limm = 32'h0;
  logic [31:0] e_tgt = 32'h0;
  logic [1:0] e_wb = 2'h0;
  logic [6:0] e_fcd = 7'h00;
  logic e_x = 1'b0;
  int bad_count = 0, cmp_count = 0, seed;
  always #4 core_clk = ~core_clk;
  fetch_model fm (.core_clk, .rst_n, .req_valid, .req_word, .instr_valid,
    .instr_word, .instr_addr, .limm_word);
  mixed_width_instr_decode dut (.*);
  function automatic logic [5:0] cmap(logic [2:0] s);
    return {2'b00, s[2], s[2], s[1:0]};
  endfunction
  function automatic logic [17:0] ops(logic [31:0] w);
    if (w[31:27] >= instr_decode_pkg::FULL_GROUPS)
      return {cmap(w[18:16]), cmap(w[21:19]), cmap(w[18:16])};
    return {w[11:6], w[17:12], w[5:0]};
  endfunction
  function automatic logic [7:0] flg(logic [31:0] w, logic u);
    logic c, g4, st;
    c  = w[31:27] >= instr_decode_pkg::FULL_GROUPS;
    g4 = !c && w[31:27] == instr_decode_pkg::GRP_AUX;
    st = g4 && w[26:24] == instr_decode_pkg::MINOR_AUX_ST;
    return {c, !c && w[11:6] == 6'h3E, !c && w[17:12] == 6'h3E,
      !c && w[11:6] == 6'h3F, !c && w[17:12] == 6'h3F,
      u && (st || (!c && w[31:27] == instr_decode_pkg::GRP_PRIV)),
      g4 && w[26:24] == instr_decode_pkg::MINOR_AUX_LD, st && !u};
  endfunction
  // Write enable and branch flag expected for one word
  function automatic logic [1:0] wr_br(logic [31:0] w, logic u);
    logic [4:0] g;
    logic c, den, br;
    g  = w[31:27];
    c  = g >= instr_decode_pkg::FULL_GROUPS;
    br = c ? g == instr_decode_pkg::GRP_CBRANCH
           : g == instr_decode_pkg::GRP_BRANCH;
    den = c ? (g != instr_decode_pkg::GRP_CTEST) && !br
            : (w[5:0] != instr_decode_pkg::PC_REG)
              && (w[5:0] != instr_decode_pkg::LIMM_REG) && !br;
    if (!c && g == instr_decode_pkg::GRP_AUX)
      den = den && (w[26:24] == instr_decode_pkg::MINOR_AUX_LD);
    if (!c && u && g == instr_decode_pkg::GRP_PRIV)
      den = 1'b0;
    return {den, br};
  endfunction
  function automatic logic in_ext(logic [5:0] r);
    return (r >= instr_decode_pkg::EXT_FIRST)
        && (r <= instr_decode_pkg::EXT_LAST);
  endfunction
  // Halfword displacement from the aligned fetch address
  function automatic logic [31:0] tgt(logic [31:0] w, logic [31:0] a);
    if (w[31:27] >= instr_decode_pkg::FULL_GROUPS)
      return {a[31:2], 2'b00} + {{22{w[24]}}, w[24:16], 1'b0};
    return {a[31:2], 2'b00} + {{7{w[23]}}, w[23:0], 1'b0};
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(logic v, logic [31:0] w, logic eu, logic ek);
    @(posedge core_clk);
    req_valid <= v;
    req_word <= w;
    enter_user <= eu;
    enter_kernel <= ek;
    #1;
    chk(dec_valid, e_v);
    chk(user_mode, e_user);
    if (e_v) begin
      chk({dec_src1, dec_src2, dec_dst}, e_ops);
      chk({dec_is_compact, dec_src1_limm, dec_src2_limm, dec_src1_pc,
        dec_src2_pc, priv_exception, aux_load_instr, aux_store_instr},
        e_flg);
      chk(aligned_pc_source, e_pc);
      if (e_flg[6] || e_flg[5]) chk(dec_limm, e_limm);
      chk({dec_flag_en, dec_cond, dec_delay_slot}, e_fcd);
      chk({dec_dst_en, dec_is_branch, dec_uses_ext_reg}, {e_wb, e_x});
      if (e_wb[0]) chk(dec_branch_target, e_tgt);
    end
    e_v = instr_valid;
    e_ops = ops(instr_word);
    e_flg = flg(instr_word, mode_reg);
    e_cf = instr_word[31:27] == 5'h0F && instr_word[24:22] <= 3'h2;
    e_fcd = e_flg[7] ? {e_cf, 6'h00}
          : {instr_word[18], instr_word[23:19], instr_word[23]};
    e_wb = wr_br(instr_word, mode_reg);
    e_x = in_ext(e_ops[17:12]) || in_ext(e_ops[11:6])
       || (e_wb[1] && in_ext(e_ops[5:0]));
    e_tgt = tgt(instr_word, instr_addr);
    e_pc = {instr_addr[31:2], 2'b00};
    e_limm = limm_word;
    mode_reg = enter_kernel ? 1'b0 : (enter_user ? 1'b1 : mode_reg);
    e_user = mode_reg;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    seed = $urandom(32'hD8612253);
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    // Mixed random stream, about one idle cycle in four, with sparse mode changes
    repeat (400) step(($urandom % 4) != 0, $urandom,
      ($urandom % 16) == 0, ($urandom % 16) == 0);
    $display("test random done");
    // Corners: both mode pulses, privileged groups, compact test minors
    step(1'b0, 32'h0, 1'b1, 1'b1);
    step(1'b1, 32'h2ABC_DEF3, 1'b0, 1'b0);
    step(1'b1, 32'h21FF_FFBE, 1'b1, 1'b0);
    step(1'b1, 32'h2ABC_DEF3, 1'b0, 1'b0);
    step(1'b1, 32'h2123_4F80, 1'b0, 1'b0);
    step(1'b1, 32'h2012_3FFE, 1'b0, 1'b1);
    step(1'b1, 32'h2ABC_DEF3, 1'b0, 1'b0);
    step(1'b1, 32'h2000_003F, 1'b0, 1'b0);
    for (int m = 0; m < 8; m++)
      step(1'b1, {5'h0F, 2'b00, m[2:0], 22'h2DA5A5}, 1'b0, 1'b0);
    step(1'b1, 32'hF3FF_0000, 1'b0, 1'b0);
    step(1'b0, 32'h0, 1'b0, 1'b0);
    $display("test corners done");
    close_out();
  end
endmodule // tb
